// [common/stc_pkg.sv]
// Purpose: Shared constants and check functions for the checked serial link
// Assumes: MSB-first bytes, 8-bit command, 1 to 4 payload bytes
// Notes:   Used by both link ends

package stc_pkg;

   // ==========================================================
   // Timing
   localparam int MCLK_PERIOD_NS = 100;
   localparam int SCLK_PERIOD_NS = 800;
   localparam int SCLK_HALF      = SCLK_PERIOD_NS / MCLK_PERIOD_NS / 2;

   // ==========================================================
   // Checking modes
   localparam logic [1:0] MODE_OFF  = 2'h0;
   localparam logic [1:0] MODE_XOR  = 2'h1;
   localparam logic [1:0] MODE_POLY = 2'h2;

   // ==========================================================
   // Frame layout
   localparam logic [7:0] POLY_LOW         = 8'h07; // x^8 term implied
   localparam logic [7:0] CONT_CMD         = 8'h44;
   localparam int         CMD_RD_BIT       = 6;
   localparam logic [5:0] ADDR_STATUS      = 6'h00;
   localparam logic [5:0] ADDR_DATA        = 6'h04;
   localparam logic [5:0] ADDR_WIDE        = 6'h10;
   localparam int         STAT_CRC_ERR_BIT = 6;

   // ==========================================================
   // One message bit into the polynomial remainder
   function automatic logic [7:0] stc_crc_bit(input logic [7:0] crc, input logic b);
      logic fb;
      fb = crc[7] ^ b;
      return {crc[6:0], 1'b0} ^ (fb ? POLY_LOW : 8'h00);
   endfunction : stc_crc_bit

   // One message bit into the bytewise XOR
   function automatic logic [7:0] stc_xor_bit(input logic [7:0] x, input logic b);
      return {x[6:0], x[7] ^ b};
   endfunction : stc_xor_bit

   // One whole byte into the remainder
   function automatic logic [7:0] stc_crc_byte(input logic [7:0] crc, input logic [7:0] d);
      logic [7:0] c;
      c = crc;
      for (int i = 7; i >= 0; i--)
         c = stc_crc_bit(c, d[i]);
      return c;
   endfunction : stc_crc_byte

   // Payload bytes of a register
   function automatic logic [2:0] stc_pay_len(input logic [5:0] addr, input logic rd);
      if (addr == ADDR_STATUS)
         return 3'h1;
      else if (addr == ADDR_DATA)
         return rd ? 3'h4 : 3'h3;
      else if (addr < ADDR_WIDE)
         return 3'h2;
      else
         return 3'h3;
   endfunction : stc_pay_len

   // Check byte over command then low len bytes of data
   function automatic logic [7:0] stc_chk(input logic [1:0] mode, input logic [7:0] cmd,
                                          input logic [31:0] data, input logic [2:0] len);
      logic [7:0] c;
      logic [7:0] x;
      c = stc_crc_byte(8'h00, cmd);
      x = cmd;
      for (int i = 3; i >= 0; i--)
      begin
         if (i < int'(len))
         begin
            c = stc_crc_byte(c, data[8*i +: 8]);
            x = x ^ data[8*i +: 8];
         end
      end
      return (mode == MODE_XOR) ? x : c;
   endfunction : stc_chk

endpackage : stc_pkg

// [common/stc_link_if.sv]
// Purpose: Four-wire serial link between host and device
// Assumes: Clock idles high, data changes on falling, sampled on rising
// Notes:   All wires driven by one end only

`timescale 1ns/100ps

interface stc_link_if;
   logic cs_n;
   logic sclk;
   logic din;
   logic dout;

   modport dev  (input cs_n, input sclk, input din, output dout);
   modport host (output cs_n, output sclk, output din, input dout);
endinterface : stc_link_if

// [hw/stc_dev.sv]
// Purpose: Device end of the checked serial register link
// Assumes: Link pins asynchronous to mclk, sclk well below mclk/6
// Notes:   Register side reads reg_rdata in the same cycle as reg_addr and reg_rd
//
// Operation
// - Write check always uses polynomial 0x107
// - Bad write check sets failure flag
// - Read check by polynomial or XOR per mode
// - Mode off: no check byte either way
// - Check byte follows last data byte
// - Write check covers command and payload
// - Read check covers command and payload
// - Continuous read implies command 0x44
// - Remainder of message shifted eight zeros
// - XOR check xors all message bytes
// - Host should read back written registers
// - Status read clears failure flag

`timescale 1ns/100ps

module stc_dev
(
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rstn,
   // Serial link
   stc_link_if.dev          lnk,
   // Mode control
   input  wire logic [1:0]  chk_mode,
   input  wire logic        cont_rd,
   // Register side
   output logic      [5:0]  reg_addr,
   output logic      [23:0] reg_wdata,
   output logic             reg_wr,
   output logic             reg_rd,
   input  wire logic [31:0] reg_rdata,
   // Status
   output logic             crc_err
);

   // ==========================================================
   // Declarations
   logic [2:0]  cs_sy_ff;
   logic [2:0]  sck_sy_ff;
   logic [1:0]  din_sy_ff;
   logic        cs_act;
   logic        cs_fall;
   logic        sck_rise;
   logic        sck_fall;
   logic        din_s;
   logic        rise_in;
   logic [5:0]  cnt_ff;
   logic        cont_ff;
   logic [7:0]  cmd_ff;
   logic [23:0] rx_ff;
   logic [7:0]  crc_ff;
   logic [5:0]  reg_addr_ff;
   logic [23:0] reg_wdata_ff;
   logic        reg_wr_ff;
   logic        ld_pend_ff;
   logic        err_ff;
   logic [39:0] tx_ff;
   logic        dout_ff;
   logic        is_rd;
   logic        chk_on;
   logic [2:0]  wr_len;
   logic [5:0]  pay_end;
   logic        cmd_done;
   logic        pay_done;
   logic        chk_done;
   logic        chk_bad;
   logic [7:0]  rx_byte;
   logic [23:0] wdata_now;
   logic [23:0] wmask;
   logic [2:0]  rd_len;
   logic [7:0]  stat_byte;
   logic [31:0] rd_val;
   logic [7:0]  rd_chk;
   logic [5:0]  rd_sh;
   logic [39:0] tx_load;

   // ==========================================================
   // Pin synchronisers
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         cs_sy_ff  <= 3'h7;
         sck_sy_ff <= 3'h7;
         din_sy_ff <= 2'h0;
      end
      else
      begin
         cs_sy_ff  <= {cs_sy_ff[1:0], lnk.cs_n};
         sck_sy_ff <= {sck_sy_ff[1:0], lnk.sclk};
         din_sy_ff <= {din_sy_ff[0], lnk.din};
      end
   end

   // Edges seen on second and third stages only
   assign cs_act   = !cs_sy_ff[1];
   assign cs_fall  = cs_sy_ff[2] && !cs_sy_ff[1];
   assign sck_rise = !sck_sy_ff[2] && sck_sy_ff[1];
   assign sck_fall = sck_sy_ff[2] && !sck_sy_ff[1];
   assign din_s    = din_sy_ff[1];
   assign rise_in  = sck_rise && cs_act && !cont_ff;

   // ==========================================================
   // Frame decode
   assign is_rd     = cmd_ff[stc_pkg::CMD_RD_BIT];
   assign chk_on    = (chk_mode != stc_pkg::MODE_OFF);
   assign wr_len    = stc_pkg::stc_pay_len(cmd_ff[5:0], is_rd);
   assign pay_end   = {wr_len, 3'h0} + 6'h08;
   assign rx_byte   = {rx_ff[6:0], din_s};
   assign wdata_now = {rx_ff[22:0], din_s};
   assign wmask     = 24'hFFFFFF >> {3'h3 - wr_len, 3'h0};
   assign cmd_done  = rise_in && (cnt_ff == 6'h07);
   assign pay_done  = rise_in && !is_rd && (cnt_ff == pay_end - 6'h01);
   assign chk_done  = rise_in && !is_rd && chk_on && (cnt_ff == pay_end + 6'h07);
   assign chk_bad   = chk_done && (rx_byte != crc_ff);

   // Bit counter, cleared outside a frame
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         cnt_ff <= 6'h00;
      else if (!cs_act)
         cnt_ff <= 6'h00;
      else if (sck_rise && cnt_ff != 6'h3F)
         cnt_ff <= cnt_ff + 6'h01;
   end

   // Command capture, implied command in continuous read
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         cont_ff <= 1'b0;
         cmd_ff  <= 8'h00;
      end
      else if (cs_fall)
      begin
         cont_ff <= cont_rd;
         cmd_ff  <= cont_rd ? stc_pkg::CONT_CMD : 8'h00;
      end
      else if (cmd_done)
         cmd_ff <= rx_byte;
   end

   // Input shifter
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         rx_ff <= 24'h000000;
      else if (sck_rise && cs_act)
         rx_ff <= wdata_now;
   end

   // Running write remainder over command and payload
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         crc_ff <= 8'h00;
      else if (cs_fall)
         crc_ff <= 8'h00;
      else if (rise_in && cnt_ff < pay_end)
         crc_ff <= stc_pkg::stc_crc_bit(crc_ff, din_s);
   end

   // ==========================================================
   // Register side
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         reg_addr_ff <= 6'h00;
         ld_pend_ff  <= 1'b0;
      end
      else
      begin
         ld_pend_ff <= (cmd_done && rx_byte[stc_pkg::CMD_RD_BIT]) || (cs_fall && cont_rd);
         if (cs_fall && cont_rd)
            reg_addr_ff <= stc_pkg::ADDR_DATA;
         else if (cmd_done)
            reg_addr_ff <= rx_byte[5:0];
      end
   end

   // Write data and commit strobe
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         reg_wdata_ff <= 24'h000000;
         reg_wr_ff    <= 1'b0;
      end
      else
      begin
         if (pay_done)
            reg_wdata_ff <= wdata_now & wmask;
         reg_wr_ff <= (pay_done && !chk_on) || (chk_done && !chk_bad);
      end
   end

   // Failure flag, a new failure beats the clear
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         err_ff <= 1'b0;
      else if (chk_bad)
         err_ff <= 1'b1;
      else if (ld_pend_ff && reg_addr_ff == stc_pkg::ADDR_STATUS)
         err_ff <= 1'b0;
   end

   // ==========================================================
   // Read frame build
   always_comb
   begin
      rd_len    = stc_pkg::stc_pay_len(reg_addr_ff, 1'b1);
      stat_byte = 8'h00;
      stat_byte[stc_pkg::STAT_CRC_ERR_BIT] = err_ff;
      rd_val    = (reg_addr_ff == stc_pkg::ADDR_STATUS) ? {24'h000000, stat_byte} : reg_rdata;
      rd_chk    = chk_on ? stc_pkg::stc_chk(chk_mode, cmd_ff, rd_val, rd_len) : 8'h00;
      rd_sh     = {3'h4 - rd_len, 3'h0};
      tx_load   = ({rd_val, 8'h00} << rd_sh) | ({32'h00000000, rd_chk} << rd_sh);
   end

   // Output shifter, one bit per falling edge
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         tx_ff   <= 40'h0000000000;
         dout_ff <= 1'b1;
      end
      else if (!cs_act)
      begin
         tx_ff   <= 40'h0000000000;
         dout_ff <= 1'b1;
      end
      else if (ld_pend_ff)
         tx_ff <= tx_load;
      else if (sck_fall)
      begin
         dout_ff <= tx_ff[39];
         tx_ff   <= {tx_ff[38:0], 1'b0};
      end
   end

   // ==========================================================
   // Outputs
   assign lnk.dout  = dout_ff;
   assign reg_addr  = reg_addr_ff;
   assign reg_wdata = reg_wdata_ff;
   assign reg_wr    = reg_wr_ff;
   assign reg_rd    = ld_pend_ff;
   assign crc_err   = err_ff;

endmodule : stc_dev

// [hw/stc_host.sv]
// Purpose: Host end of the checked serial register link
// Assumes: Device end as in stc_dev, same mclk rate
// Notes:   Makes sclk by dividing mclk; dout sampled late in high phase

`timescale 1ns/100ps

module stc_host
(
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rstn,
   // Serial link
   stc_link_if.host         lnk,
   // Mode control
   input  wire logic [1:0]  chk_mode,
   input  wire logic        cont_rd,
   // Request
   input  wire logic        req,
   input  wire logic        req_rd,
   input  wire logic [5:0]  req_addr,
   input  wire logic [23:0] req_wdata,
   // Answer
   output logic             busy,
   output logic             done,
   output logic      [31:0] rd_data,
   output logic             rd_bad
);

   typedef enum logic [4:0] {
      ST_IDLE  = 5'b00001,
      ST_SETUP = 5'b00010,
      ST_LOW   = 5'b00100,
      ST_HIGH  = 5'b01000,
      ST_END   = 5'b10000
   } stc_hst_t;

   // ==========================================================
   // Declarations
   stc_hst_t    st_ff;
   logic [2:0]  div_ff;
   logic        tick;
   logic        last;
   logic        go_low;
   logic [1:0]  dout_sy_ff;
   logic        dout_s;
   logic [5:0]  bit_ff;
   logic [5:0]  pre_ff;
   logic [5:0]  pend_ff;
   logic [5:0]  nbits_ff;
   logic        rd_ff;
   logic [1:0]  mode_ff;
   logic [47:0] tx_ff;
   logic [7:0]  crc_ff;
   logic [7:0]  xor_ff;
   logic [31:0] rxd_ff;
   logic [7:0]  rxc_ff;
   logic        cs_n_ff;
   logic        sclk_ff;
   logic        din_ff;
   logic        done_ff;
   logic        bad_ff;
   logic [31:0] rd_data_ff;
   logic        rd_h;
   logic [2:0]  len_h;
   logic [7:0]  cmd_h;
   logic [5:0]  pre_h;
   logic [5:0]  pend_h;
   logic [7:0]  wcrc_h;
   logic [5:0]  sh_h;
   logic [39:0] pl_h;

   // ==========================================================
   // Request decode
   always_comb
   begin
      rd_h   = req_rd || cont_rd;
      len_h  = stc_pkg::stc_pay_len(cont_rd ? stc_pkg::ADDR_DATA : req_addr, rd_h);
      cmd_h  = {2'h0, req_addr};
      cmd_h[stc_pkg::CMD_RD_BIT] = req_rd;
      if (cont_rd)
         cmd_h = stc_pkg::CONT_CMD;
      pre_h  = cont_rd ? 6'h00 : 6'h08;
      pend_h = pre_h + {len_h, 3'h0};
      wcrc_h = stc_pkg::stc_chk(stc_pkg::MODE_POLY, cmd_h, {8'h00, req_wdata}, len_h);
      sh_h   = {3'h4 - len_h, 3'h0};
      pl_h   = ({8'h00, req_wdata, 8'h00} << sh_h) | ({32'h00000000, wcrc_h} << sh_h);
   end

   // ==========================================================
   // Half-period divider and sequencing
   assign tick   = (st_ff != ST_IDLE) && (div_ff == 3'(stc_pkg::SCLK_HALF - 1));
   assign last   = (bit_ff == nbits_ff - 6'h01);
   assign go_low = tick && (st_ff == ST_SETUP || (st_ff == ST_HIGH && !last));

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         div_ff <= 3'h0;
      else if (st_ff == ST_IDLE || tick)
         div_ff <= 3'h0;
      else
         div_ff <= div_ff + 3'h1;
   end

   // Frame state
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         st_ff <= ST_IDLE;
      else
      begin
         unique case (st_ff)
            ST_IDLE:  if (req) st_ff <= ST_SETUP;
            ST_SETUP: if (tick) st_ff <= ST_LOW;
            ST_LOW:   if (tick) st_ff <= ST_HIGH;
            ST_HIGH:  if (tick) st_ff <= last ? ST_END : ST_LOW;
            ST_END:   if (tick) st_ff <= ST_IDLE;
            default:  st_ff <= ST_IDLE;
         endcase
      end
   end

   // Frame setup and transmit
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         rd_ff    <= 1'b0;
         mode_ff  <= stc_pkg::MODE_OFF;
         pre_ff   <= 6'h00;
         pend_ff  <= 6'h00;
         nbits_ff <= 6'h00;
         tx_ff    <= 48'h000000000000;
         din_ff   <= 1'b0;
      end
      else if (st_ff == ST_IDLE && req)
      begin
         rd_ff    <= rd_h;
         mode_ff  <= chk_mode;
         pre_ff   <= pre_h;
         pend_ff  <= pend_h;
         nbits_ff <= pend_h + ((chk_mode != stc_pkg::MODE_OFF) ? 6'h08 : 6'h00);
         tx_ff    <= cont_rd ? 48'h000000000000 : {cmd_h, rd_h ? 40'h0000000000 : pl_h};
      end
      else if (go_low)
      begin
         din_ff <= tx_ff[47];
         tx_ff  <= {tx_ff[46:0], 1'b0};
      end
   end

   // Pin drive
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         cs_n_ff <= 1'b1;
         sclk_ff <= 1'b1;
      end
      else
      begin
         if (st_ff == ST_IDLE && req)
            cs_n_ff <= 1'b0;
         else if (st_ff == ST_END && tick)
            cs_n_ff <= 1'b1;
         if (go_low)
            sclk_ff <= 1'b0;
         else if (st_ff == ST_LOW && tick)
            sclk_ff <= 1'b1;
      end
   end

   // ==========================================================
   // Receive path
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         dout_sy_ff <= 2'h3;
      else
         dout_sy_ff <= {dout_sy_ff[0], lnk.dout};
   end

   assign dout_s = dout_sy_ff[1];

   // Bit count and checks over command and returned payload
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         bit_ff <= 6'h00;
         crc_ff <= 8'h00;
         xor_ff <= 8'h00;
         rxd_ff <= 32'h00000000;
         rxc_ff <= 8'h00;
      end
      else if (st_ff == ST_IDLE && req)
      begin
         bit_ff <= 6'h00;
         crc_ff <= stc_pkg::stc_crc_byte(8'h00, cmd_h);
         xor_ff <= cmd_h;
         rxd_ff <= 32'h00000000;
         rxc_ff <= 8'h00;
      end
      else if (st_ff == ST_HIGH && tick)
      begin
         bit_ff <= bit_ff + 6'h01;
         if (rd_ff && bit_ff >= pre_ff && bit_ff < pend_ff)
         begin
            rxd_ff <= {rxd_ff[30:0], dout_s};
            crc_ff <= stc_pkg::stc_crc_bit(crc_ff, dout_s);
            xor_ff <= stc_pkg::stc_xor_bit(xor_ff, dout_s);
         end
         else if (rd_ff && bit_ff >= pend_ff)
            rxc_ff <= {rxc_ff[6:0], dout_s};
      end
   end

   // Result at frame end
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         done_ff    <= 1'b0;
         bad_ff     <= 1'b0;
         rd_data_ff <= 32'h00000000;
      end
      else
      begin
         done_ff <= (st_ff == ST_END) && tick;
         if (st_ff == ST_END && tick)
         begin
            rd_data_ff <= rxd_ff;
            bad_ff     <= rd_ff && (mode_ff != stc_pkg::MODE_OFF) &&
                          (rxc_ff != ((mode_ff == stc_pkg::MODE_XOR) ? xor_ff : crc_ff));
         end
      end
   end

   // ==========================================================
   // Outputs
   assign lnk.cs_n = cs_n_ff;
   assign lnk.sclk = sclk_ff;
   assign lnk.din  = din_ff;
   assign busy     = (st_ff != ST_IDLE);
   assign done     = done_ff;
   assign rd_data  = rd_data_ff;
   assign rd_bad   = bad_ff;

endmodule : stc_host

// [tb/stc_assertions.sv]
// Purpose: Wire checks on the host link
// Assumes: Mode and cont_rd steady per frame
// Notes:   Rebuilds message bits at sclk rises
`timescale 1ns/100ps
module stc_assertions
(
   // Clock and reset
   input wire logic       mclk,
   input wire logic       rstn,
   // Link wires
   input wire logic       cs_n,
   input wire logic       sclk,
   input wire logic       din,
   input wire logic       dout,
   // Mode control
   input wire logic [1:0] chk_mode,
   input wire logic       cont_rd
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   // ==========================================================
   // Frame remainders
   logic [5:0] cnt_ff;
   logic [7:0] wcrc_ff;
   logic [7:0] mcrc_ff;
   logic [7:0] mxor_ff;
   logic [1:0] mode_ff;
   logic       rd_ff;
   logic       cont_ff;
   logic       bit_in;
   // Command from din, rest from dout
   assign bit_in = (cnt_ff < 6'h08 && !cont_ff) ? din : dout;
   // Frame remainders
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         cnt_ff  <= 6'h00;
         wcrc_ff <= 8'h00;
         mcrc_ff <= 8'h00;
         mxor_ff <= 8'h00;
         mode_ff <= 2'h0;
         rd_ff   <= 1'b0;
         cont_ff <= 1'b0;
      end
      else if ($fell(cs_n))
      begin
         cnt_ff  <= 6'h00;
         wcrc_ff <= 8'h00;
         mcrc_ff <= cont_rd ? 8'hDB : 8'h00;
         mxor_ff <= cont_rd ? 8'h44 : 8'h00;
         mode_ff <= chk_mode;
         rd_ff   <= 1'b0;
         cont_ff <= cont_rd;
      end
      else if ($rose(sclk) && !cs_n)
      begin
         cnt_ff  <= cnt_ff + 6'h01;
         wcrc_ff <= {wcrc_ff[6:0], 1'b0} ^ ((wcrc_ff[7] ^ din) ? 8'h07 : 8'h00);
         mcrc_ff <= {mcrc_ff[6:0], 1'b0} ^ ((mcrc_ff[7] ^ bit_in) ? 8'h07 : 8'h00);
         mxor_ff <= {mxor_ff[6:0], mxor_ff[7] ^ bit_in};
         rd_ff   <= (cnt_ff == 6'h01) ? din : rd_ff;
      end
   end
   // ==========================================================
   // Checks
   a_sclk_idle_high: assert property (cs_n |-> sclk)
      else $error("sclk low outside a frame");
   a_dout_idle_one: assert property (cs_n && $past(cs_n, 6) |-> dout)
      else $error("dout not idle high");
   a_lead_time: assert property ($fell(cs_n) |-> sclk [*4])
      else $error("sclk lead too short");
   a_low_phase: assert property ($fell(sclk) |-> !sclk [*4] ##1 sclk)
      else $error("sclk low phase wrong");
   a_high_phase: assert property ($rose(sclk) && !cs_n |-> sclk [*4])
      else $error("sclk high phase too short");
   a_frame_bytes: assert property ($rose(cs_n) && mode_ff != 2'h0
      |-> cnt_ff[2:0] == 3'h0 && cnt_ff >= 6'h18)
      else $error("frame length wrong");
   a_write_check: assert property ($rose(cs_n) && !rd_ff && !cont_ff && mode_ff != 2'h0
      |-> wcrc_ff == 8'h00)
      else $error("write check byte wrong");
   a_read_poly: assert property ($rose(cs_n) && (rd_ff || cont_ff) && mode_ff[1]
      |-> mcrc_ff == 8'h00)
      else $error("read poly check wrong");
   a_read_xor: assert property ($rose(cs_n) && (rd_ff || cont_ff) && mode_ff == 2'h1
      |-> mxor_ff == 8'h00)
      else $error("read xor check wrong");
endmodule : stc_assertions

// [tb/tb_serial_transaction_checksum.sv]
// Purpose: Bench for both link ends
// Assumes: Register side is an address pattern
// Notes:   Second link is hand driven
`timescale 1ns/100ps
module tb_serial_transaction_checksum;
   // ==========================================================
   // Signals
   logic        mclk  = 1'b0;
   logic        rstn  = 1'b0;
   int          miscompares = 0;
   int          tests_run   = 0;
   int          cyc = 0;
   int          nb  = 0;
   int          wrn = 0;
   int          wr2n = 0;
   logic [1:0]  mode = 2'h2;
   logic        cont = 1'b0;
   logic        req  = 1'b0;
   logic        rq_rd = 1'b0;
   logic [5:0]  rq_addr = 6'h00;
   logic [23:0] rq_wd = 24'h0;
   logic        busy, done, rd_bad, rwr, crc_err, rwr2, err2, sc_q;
   logic [31:0] rd_data, rdat, rdat2;
   logic [5:0]  ra, ra2;
   logic [23:0] rwd;
   logic [63:0] wb, rb;
   stc_link_if lk ();
   stc_link_if lk2 ();
   // Register side pattern
   assign rdat  = {4{2'b01, ra}} ^ 32'h0F1E2D3C;
   assign rdat2 = {4{2'b01, ra2}} ^ 32'h0F1E2D3C;
   // ==========================================================
   // Instances
   stc_host stc_host_i (.mclk(mclk), .rstn(rstn), .lnk(lk.host), .chk_mode(mode),
      .cont_rd(cont), .req(req), .req_rd(rq_rd), .req_addr(rq_addr), .req_wdata(rq_wd),
      .busy(busy), .done(done), .rd_data(rd_data), .rd_bad(rd_bad));
   stc_dev stc_dev_i (.mclk(mclk), .rstn(rstn), .lnk(lk.dev), .chk_mode(mode),
      .cont_rd(cont), .reg_addr(ra), .reg_wdata(rwd), .reg_wr(rwr), .reg_rd(),
      .reg_rdata(rdat), .crc_err(crc_err));
   stc_dev stc_dev_i2 (.mclk(mclk), .rstn(rstn), .lnk(lk2.dev), .chk_mode(2'h2),
      .cont_rd(1'b0), .reg_addr(ra2), .reg_wdata(), .reg_wr(rwr2), .reg_rd(),
      .reg_rdata(rdat2), .crc_err(err2));
   stc_assertions stc_assertions_i (.mclk(mclk), .rstn(rstn), .cs_n(lk.cs_n),
      .sclk(lk.sclk), .din(lk.din), .dout(lk.dout), .chk_mode(mode), .cont_rd(cont));
   // Clock
   initial
   begin
      forever #50 mclk = ~mclk;
   end
   // Capture and timeout
   always @(posedge mclk)
   begin
      sc_q <= lk.sclk;
      cyc  <= cyc + 1;
      if (!lk.cs_n && lk.sclk && !sc_q)
      begin
         nb <= nb + 1;
         wb <= {wb[62:0], lk.din};
         rb <= {rb[62:0], lk.dout};
      end
      wrn  <= wrn + int'(rwr);
      wr2n <= wr2n + int'(rwr2);
      if (cyc == 20000)
      begin
         miscompares = miscompares + 1;
         end_of_test();
      end
   end
   // ==========================================================
   // Helpers
   function automatic logic [7:0] ref_crc(input logic [63:0] m, input int n);
      logic [7:0] c;
      c = 8'h00;
      for (int i = n - 1; i >= 0; i--)
         c = {c[6:0], 1'b0} ^ ((c[7] ^ m[i]) ? 8'h07 : 8'h00);
      return c;
   endfunction : ref_crc
   function automatic logic [7:0] ref_xor(input logic [63:0] m, input int n);
      logic [7:0] x;
      x = 8'h00;
      for (int i = 0; i < n; i += 8)
         x = x ^ m[i +: 8];
      return x;
   endfunction : ref_xor
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      tests_run = tests_run + 1;
      if (seen !== exp)
      begin
         miscompares = miscompares + 1;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // Host request
   task automatic hreq(input logic [1:0] m, input logic c, input logic rd,
                       input logic [5:0] a, input logic [23:0] wd);
      int n;
      n = 0;
      @(posedge mclk);
      nb = 0;
      mode    <= m;
      cont    <= c;
      req     <= 1'b1;
      rq_rd   <= rd;
      rq_addr <= a;
      rq_wd   <= wd;
      @(posedge mclk);
      req <= 1'b0;
      while (done !== 1'b1 && n < 1000)
      begin
         @(negedge mclk);
         n++;
      end
      chk(n < 1000, 1'b1);
      chk(busy, 1'b0);
      repeat (4) @(posedge mclk);
   endtask : hreq
   // Frame on second link
   task automatic bb(input logic [63:0] v, input int n, output logic [63:0] cap);
      cap = 64'h0;
      @(posedge mclk);
      lk2.cs_n <= 1'b0;
      repeat (4) @(posedge mclk);
      for (int i = n - 1; i >= 0; i--)
      begin
         lk2.sclk <= 1'b0;
         lk2.din  <= v[i];
         repeat (4) @(posedge mclk);
         lk2.sclk <= 1'b1;
         repeat (4) @(posedge mclk);
         cap = {cap[62:0], lk2.dout};
      end
      lk2.cs_n <= 1'b1;
      lk2.din  <= ~v[0];
      repeat (8) @(posedge mclk);
   endtask : bb
   // ==========================================================
   // Scenarios
   task automatic t_write(input logic [1:0] m, input logic [5:0] a,
                          input logic [23:0] wd, input int len);
      logic [63:0] msg;
      int          w0;
      msg = {40'h0, wd} | ({58'h0, a} << (8 * len));
      w0  = wrn;
      hreq(m, 1'b0, 1'b0, a, wd);
      chk(nb, 8 * len + (m == 2'h0 ? 8 : 16));
      chk(wb[7:0], m == 2'h0 ? wd[7:0] : ref_crc(msg, 8 * len + 8));
      chk(wrn, w0 + 1);
      chk({ra, rwd}, {a, wd});
      chk(crc_err, 1'b0);
      $display("test write %0d done", m);
   endtask : t_write
   task automatic t_read(input logic [1:0] m, input logic [5:0] a, input int len);
      logic [63:0] d;
      logic [63:0] msg;
      d   = {32'h0, {4{2'b01, a}} ^ 32'h0F1E2D3C} & ((64'h1 << (8 * len)) - 64'h1);
      msg = d | ({56'h0, 2'b01, a} << (8 * len));
      hreq(m, 1'b0, 1'b1, a, 24'h0);
      chk({rd_bad, rd_data}, d);
      chk(nb, 8 * len + (m == 2'h0 ? 8 : 16));
      if (m != 2'h0)
         chk(rb[7:0], m == 2'h1 ? ref_xor(msg, 8 * len + 8) : ref_crc(msg, 8 * len + 8));
      $display("test read %0d done", m);
   endtask : t_read
   task automatic t_cont(input logic [1:0] m);
      logic [63:0] d;
      logic [63:0] msg;
      d   = {32'h0, 32'h44444444 ^ 32'h0F1E2D3C};
      msg = d | 64'h4400000000;
      hreq(m, 1'b1, 1'b1, 6'h04, 24'h0);
      chk({rd_bad, rd_data}, d);
      chk(nb, 40);
      chk(rb[7:0], m == 2'h1 ? ref_xor(msg, 40) : ref_crc(msg, 40));
      $display("test cont %0d done", m);
   endtask : t_cont
   task automatic t_bad();
      logic [63:0] cap;
      logic [7:0]  c;
      int          w0;
      w0 = wr2n;
      c  = ref_crc(64'h01BEEF, 24);
      bb({32'h0, 24'h01BEEF, c ^ 8'h01}, 32, cap);
      chk({err2, wr2n}, {1'b1, w0});
      bb({32'h0, 24'h01BEEF, c}, 32, cap);
      chk({err2, wr2n}, {1'b1, w0 + 1});
      bb(64'h400000, 24, cap);
      chk(cap[15:0], {8'h40, ref_crc(64'h4040, 16)});
      chk(err2, 1'b0);
      bb(64'h400000, 24, cap);
      chk(cap[15:0], {8'h00, ref_crc(64'h4000, 16)});
      $display("test bad done");
   endtask : t_bad
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_of_test
   // ==========================================================
   // Main sequence
   initial
   begin
      lk2.cs_n = 1'b1;
      lk2.sclk = 1'b1;
      lk2.din  = 1'b0;
      repeat (16) @(posedge mclk);
      rstn <= 1'b1;
      repeat (4) @(posedge mclk);
      t_write(2'h2, 6'h01, 24'h001234, 2);
      t_read(2'h2, 6'h01, 2);
      t_write(2'h1, 6'h12, 24'hA5C3F0, 3);
      t_write(2'h0, 6'h05, 24'h0055AA, 2);
      t_read(2'h1, 6'h05, 2);
      t_read(2'h2, 6'h04, 4);
      t_read(2'h3, 6'h20, 3);
      t_read(2'h0, 6'h03, 2);
      t_cont(2'h2);
      t_cont(2'h1);
      t_bad();
      end_of_test();
   end
endmodule : tb_serial_transaction_checksum
